// >>> rtl/psm_ctrl.sv
// power-saving mode controller: idle and power-down entry and exit
//
// Functional notes
// - idle bit set: enter idle, halt PC
// - idle keeps clock, peripherals, interrupts running
// - idle leaves RAM and registers untouched
// - any interrupt or reset exits; clears idle
// - return resumes after idle-setting instruction
// - reset in low power acts as power-on
// - power-down bit set: enter, stop clock
// - power-down: level interrupts only, edges off
// - SRAM retained through power-down
// - exit by level interrupt or reset; clear bit
// - pin low restarts oscillator at once; 1024 low clocks needed to wake
// - pin high again: ISR first instruction runs
`timescale 1ns/1ps
module psm_ctrl (
  input wire logic clk_in, // system clock, 100 MHz
  input wire logic reset_in, // hardware reset, async active high
  input wire psm_pkg::psm_req_t req_in, // control register write from core
  input wire logic int_start_in, // core begins servicing an interrupt
  input wire logic ext_int_low_in, // external interrupt pin is low
  input wire logic ext_int_level_in, // pin configured level sensitive and enabled
  output logic [1:0] ctrl_out, // control register readback
  output psm_pkg::psm_gate_t gate_out, // gating to core and clock generator
  output logic wake_int_out // level interrupt request to core after wake
);
  import psm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  psm_state_t state_reg, state_next; // current mode
  logic [1:0] ctrl_reg, ctrl_next; // request bits
  logic [10:0] wake_cnt_reg, wake_cnt_next; // low-time counter in power-down
  logic osc_on_reg, osc_on_next; // oscillator restarted flag
  psm_gate_t gate_reg, gate_next; // registered gating
  logic wake_reg, wake_next; // registered wake interrupt

  // whether the low-time requirement has been met
  function automatic logic wake_done(input logic [10:0] cnt);
    wake_done = (cnt >= PSM_WAKE_CNT_MAX);
  endfunction : wake_done

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    wake_cnt_next = wake_cnt_reg;
    osc_on_next = osc_on_reg;
    wake_next = 1'b0;
    // software write of the request bits
    if (req_in.wr) begin
      ctrl_next = req_in.data;
    end
    unique case (state_reg)
      PSM_RUN: begin
        // power-down takes priority when both are set
        if (req_in.wr && req_in.data[PSM_PDOWN_BIT]) begin
          state_next = PSM_PDOWN;
          wake_cnt_next = PSM_WAKE_CNT_RST;
          osc_on_next = 1'b0;
        end else if (req_in.wr && req_in.data[PSM_IDLE_BIT]) begin
          state_next = PSM_IDLE;
        end
      end
      PSM_IDLE: begin
        // any serviced interrupt ends idle; core resumes after it
        if (int_start_in) begin
          ctrl_next[PSM_IDLE_BIT] = 1'b0;
          state_next = PSM_RUN;
        end
      end
      PSM_PDOWN: begin
        // only an enabled level interrupt counts; edges ignored
        if (ext_int_low_in && ext_int_level_in) begin
          osc_on_next = 1'b1;
          if (!wake_done(wake_cnt_reg)) begin
            wake_cnt_next = wake_cnt_reg + 11'h001;
          end
        end else if (!ext_int_low_in && wake_done(wake_cnt_reg)) begin
          wake_next = 1'b1;
        end else if (!ext_int_low_in) begin
          // released too early: back to sleep
          wake_cnt_next = PSM_WAKE_CNT_RST;
          osc_on_next = 1'b0;
        end
        if (int_start_in && wake_reg) begin
          ctrl_next[PSM_PDOWN_BIT] = 1'b0;
          wake_next = 1'b0; // request consumed; released pin must not raise it again
          state_next = PSM_RUN;
          osc_on_next = 1'b0;
          wake_cnt_next = PSM_WAKE_CNT_RST;
        end else if (wake_reg) begin
          wake_next = 1'b1; // hold request until core takes it
        end
      end
      default: begin
        state_next = PSM_RUN;
      end
    endcase
  end

  // gating derived from next mode; RAM/registers never written here
  always_comb begin
    gate_next.cpu_halt = (state_next != PSM_RUN);
    gate_next.clk_stop = (state_next == PSM_PDOWN) && !osc_on_next;
    gate_next.periph_run = (state_next != PSM_PDOWN);
    gate_next.edge_int_en = (state_next != PSM_PDOWN);
  end

  // ----------------------------------------------------------------
  // registers; reset restarts like power-on
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= PSM_RUN;
      ctrl_reg <= PSM_CTRL_RST;
      wake_cnt_reg <= PSM_WAKE_CNT_RST;
      osc_on_reg <= 1'b0;
      gate_reg <= PSM_GATE_RST;
      wake_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      wake_cnt_reg <= wake_cnt_next;
      osc_on_reg <= osc_on_next;
      gate_reg <= gate_next;
      wake_reg <= wake_next;
    end
  end

  // outputs straight from flip-flops
  assign ctrl_out = ctrl_reg;
  assign gate_out = gate_reg;
  assign wake_int_out = wake_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pd_req;
    state_reg == PSM_RUN && req_in.wr && req_in.data[PSM_PDOWN_BIT];
  endsequence
  sequence s_idle_req;
    state_reg == PSM_RUN && req_in.wr && req_in.data == 2'h1;
  endsequence

  chk_idle_entry: assert property (@(posedge clk_in) disable iff (reset_in)
    s_idle_req |=> gate_out.cpu_halt && !gate_out.clk_stop && state_reg == PSM_IDLE)
    else $error("idle entry did not halt core");
  chk_idle_clock: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_IDLE |-> gate_out.periph_run && !gate_out.clk_stop)
    else $error("clock or peripherals stopped in idle");
  chk_idle_exit: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_IDLE && int_start_in |=> !ctrl_out[PSM_IDLE_BIT] && state_reg == PSM_RUN)
    else $error("interrupt did not end idle");
  chk_pd_entry: assert property (@(posedge clk_in) disable iff (reset_in)
    s_pd_req |=> gate_out.clk_stop && state_reg == PSM_PDOWN)
    else $error("power-down entry did not stop clock");
  chk_pd_edges: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN |-> !gate_out.edge_int_en)
    else $error("edge interrupts active in power-down");
  chk_pd_early: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && !wake_done(wake_cnt_reg) |=> !wake_int_out)
    else $error("wake before 1024 low cycles");
  chk_pd_wake: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && wake_done(wake_cnt_reg) && !ext_int_low_in && !wake_reg
    |=> wake_int_out)
    else $error("no wake interrupt after pin release");
  chk_pd_exit: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && wake_reg && int_start_in
    |=> !ctrl_out[PSM_PDOWN_BIT] && !gate_out.cpu_halt && !wake_int_out)
    else $error("power-down bit not cleared on wake");
  chk_reset_run: assert property (@(posedge clk_in)
    $fell(reset_in) |-> ctrl_out == PSM_CTRL_RST && !gate_out.cpu_halt)
    else $error("reset did not restore run mode");

  // ----------------------------------------------------------------
  // checks on held state and on the wake handshake
  // ----------------------------------------------------------------
  // pin released after the full low time
  sequence s_wake_release;
    state_reg == PSM_PDOWN && wake_done(wake_cnt_reg) && !ext_int_low_in;
  endsequence
  // core takes the pending wake request
  sequence s_wake_taken;
    state_reg == PSM_PDOWN && wake_reg && int_start_in;
  endsequence

  // request bits hold in idle unless written or an interrupt starts
  chk_idle_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_IDLE && !int_start_in && !req_in.wr |=> $stable(ctrl_out))
    else $error("request bits changed during idle");
  // core released and peripherals still running after idle exit
  chk_idle_resume: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_IDLE && int_start_in |=> !gate_out.cpu_halt && gate_out.periph_run)
    else $error("core not released after idle exit");
  // a pin not set level sensitive never restarts the clock
  chk_pd_level: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && !osc_on_reg && !ext_int_level_in |=> gate_out.clk_stop)
    else $error("clock restarted by a pin not set level sensitive");
  // nothing held is lost while asleep and not yet woken
  chk_pd_retain: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && !wake_reg && !req_in.wr
    |=> $stable(ctrl_out) && gate_out.cpu_halt)
    else $error("state lost during power-down");
  // an enabled low level restarts the clock at once
  chk_pd_osc: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && ext_int_low_in && ext_int_level_in && !wake_reg
    |=> !gate_out.clk_stop)
    else $error("low level pin did not restart the clock");
  // the wake request only rises after the full low time
  chk_wake_count: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && $rose(wake_int_out) |-> wake_done(wake_cnt_reg))
    else $error("wake raised before the full low time");
  // the wake request stands until the core takes it
  chk_wake_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == PSM_PDOWN && wake_int_out && !int_start_in |=> wake_int_out)
    else $error("wake request dropped before the core took it");
  // taking the wake request ends power-down and drops the request
  chk_wake_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    s_wake_taken |=> !wake_int_out && state_reg == PSM_RUN && gate_out.periph_run)
    else $error("wake request not cleared on exit");
  // the clock keeps running once the pin is released after the low time
  chk_release_osc: assert property (@(posedge clk_in) disable iff (reset_in)
    s_wake_release |=> !gate_out.clk_stop)
    else $error("clock stopped again after a valid wake");

endmodule : psm_ctrl

// >>> rtl/psm_pkg.sv
// package for the power-saving mode controller
package psm_pkg;

  // ----------------------------------------------------------------
  // timing constants
  // ----------------------------------------------------------------
  localparam int unsigned PSM_CLK_MHZ = 100; // system clock rate
  localparam int unsigned PSM_WAKE_LOW_CYCLES = 1024; // least low time of wake pin, in clocks
  localparam logic [10:0] PSM_WAKE_CNT_MAX = 11'(PSM_WAKE_LOW_CYCLES); // saturating target
  localparam logic [10:0] PSM_WAKE_CNT_RST = 11'h000; // counter value after reset

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int unsigned PSM_IDLE_BIT = 0; // idle_request_bit position
  localparam int unsigned PSM_PDOWN_BIT = 1; // powerdown_request_bit position
  localparam logic [1:0] PSM_CTRL_RST = 2'h0; // control value after reset

  // mode states, one-hot
  typedef enum logic [2:0] {
    PSM_RUN = 3'h1,
    PSM_IDLE = 3'h2,
    PSM_PDOWN = 3'h4
  } psm_state_t;

  // core-side request write
  typedef struct packed {
    logic wr; // write strobe of the control register
    logic [1:0] data; // written request bits
  } psm_req_t;

  // gating outputs to core and clock generator
  typedef struct packed {
    logic cpu_halt; // program counter frozen
    logic clk_stop; // oscillator / system clock stopped
    logic periph_run; // peripherals and interrupt logic clocked
    logic edge_int_en; // edge-triggered external interrupts usable
  } psm_gate_t;

  // gating after reset: core running, clocks and peripherals on
  localparam psm_gate_t PSM_GATE_RST = '{cpu_halt: 1'b0, clk_stop: 1'b0, periph_run: 1'b1,
    edge_int_en: 1'b1};

endpackage : psm_pkg

// >>> verification/psm_core_model.sv
// far-side model: core that accepts interrupts after a service delay
`timescale 1ns/1ps
module psm_core_model (
  input wire logic clk_in, // system clock
  input wire logic reset_in, // hardware reset
  input wire logic [3:0] ack_dly_in, // service delay, prompt or slow
  input wire logic irq_req_in, // pending system interrupt from bench
  input wire logic wake_int_in, // level request after power-down wake
  output logic int_start_out // core begins servicing, one cycle
);
  int unsigned wait_cnt; // cycles spent before servicing
  initial int_start_out = 1'b0;
  // one-cycle start pulse once the delay has run out
  always @(negedge clk_in) begin
    int_start_out <= 1'b0;
    if (reset_in) begin
      wait_cnt = 0;
    end else if ((irq_req_in || wake_int_in) && !int_start_out) begin
      wait_cnt++;
      if (wait_cnt > ack_dly_in) begin
        int_start_out <= 1'b1;
        wait_cnt = 0;
      end
    end
  end
endmodule : psm_core_model

// >>> verification/tb_top.sv
// self-checking bench for the power-saving mode controller
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import psm_pkg::*;
  logic clk_in = 1'b0; // 100 MHz system clock
  logic reset_in; // async reset, held at start
  logic irq_req; // system interrupt to the core model
  logic int_start; // core begins servicing
  logic pin_low; // external interrupt pin low
  logic lvl_en; // pin enabled as level sensitive
  logic [3:0] ack_dly; // core model service delay
  psm_req_t req; // control register write
  logic [1:0] ctrl; // request bits readback
  psm_gate_t gate; // gating outputs
  logic wake; // wake interrupt request
  logic [6:0] obs; // outputs packed together
  logic [6:0] prev; // last seen outputs
  logic [6:0] exp_q[$]; // expected output changes, oldest first
  int errors = 0;
  int compares = 0;
  initial forever #5 clk_in = ~clk_in;
  psm_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req), .int_start_in(int_start),
    .ext_int_low_in(pin_low), .ext_int_level_in(lvl_en), .ctrl_out(ctrl), .gate_out(gate),
    .wake_int_out(wake));
  psm_core_model i_core (.clk_in(clk_in), .reset_in(reset_in), .ack_dly_in(ack_dly),
    .irq_req_in(irq_req), .wake_int_in(wake), .int_start_out(int_start));
  assign obs = {ctrl, gate, wake};
  // ----------------------------------------------------------------
  // watcher: every output change must match the oldest note
  // ----------------------------------------------------------------
  initial begin
    prev = 7'h06;
    forever begin
      @(negedge clk_in);
      if (obs !== prev) begin
        if (exp_q.size() == 0) `CHK(obs, prev)
        else `CHK(obs, exp_q.pop_front())
        prev = obs;
      end
    end
  end
  task automatic wr(input logic [1:0] d, input logic [6:0] e);
    exp_q.push_back(e);
    req = '{wr: 1'b1, data: d};
    @(negedge clk_in);
    req = '0;
  endtask : wr
  // system interrupt, served by the core model after a random delay
  task automatic irq(input logic [6:0] e);
    exp_q.push_back(e);
    ack_dly = 4'($urandom_range(0, 9));
    irq_req = 1'b1;
    @(posedge int_start);
    @(negedge clk_in);
    irq_req = 1'b0;
  endtask : irq
  task automatic hold_low(input int n);
    pin_low = 1'b1;
    repeat (n) @(negedge clk_in);
    pin_low = 1'b0;
    @(negedge clk_in); // pin seen high at one edge before the next press
  endtask : hold_low
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    irq_req = 1'b0;
    pin_low = 1'b0;
    lvl_en = 1'b0;
    ack_dly = 4'h2;
    req = '0;
    void'($urandom(67));
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    wr(2'h1, 7'h36);
    repeat (5) @(negedge clk_in);
    irq(7'h06);
    wr(2'h2, 7'h58);
    hold_low(20); // level disabled: no change expected
    lvl_en = 1'b1;
    exp_q.push_back(7'h50);
    exp_q.push_back(7'h58);
    hold_low(1 + $urandom_range(0, 1000));
    exp_q.push_back(7'h50);
    exp_q.push_back(7'h58);
    hold_low(PSM_WAKE_LOW_CYCLES - 1);
    exp_q.push_back(7'h50);
    exp_q.push_back(7'h51);
    exp_q.push_back(7'h06);
    hold_low(PSM_WAKE_LOW_CYCLES);
    repeat (20) @(negedge clk_in);
    wr(2'h3, 7'h78);
    exp_q.push_back(7'h06);
    reset_in = 1'b1;
    @(negedge clk_in);
    reset_in = 1'b0;
    repeat (5) @(negedge clk_in);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
  // watchdog: run needs about 3200 cycles
  initial begin
    repeat (6000) @(negedge clk_in);
    errors++;
    give_verdict();
  end
endmodule : tb_top
